// *** logic/scr_ctrl_regs.sv ***
// Control and configuration register group of the parallel bus protocol core.
`include "scr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module scr_ctrl_regs (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register access
  input wire logic i_wr,
  input wire logic i_rd,
  input wire scr_pkg::scr_addr_t i_addr,
  input wire scr_pkg::scr_byte_t i_wdata,
  output scr_pkg::scr_byte_t o_rdata,
  // Mode and bus state
  input wire logic i_target_mode_bit,
  input wire logic i_bus_free,
  input wire logic i_phase_data,
  input wire logic i_phase_cmd,
  input wire logic i_dt_xfer,
  // Script events
  input wire logic i_script_mode,
  input wire logic i_reselected,
  input wire logic i_select_done,
  input wire logic i_chained_block_move,
  input wire logic i_block_move,
  input wire logic i_table_load,
  input wire scr_pkg::scr_byte_t i_table_ctl_three,
  input wire scr_pkg::scr_byte_t i_table_sync,
  input wire logic i_dest_load,
  input wire logic [3:0] i_dest_id,
  // Transfer engine
  input wire logic i_wide_send_set,
  input wire logic i_wide_recv_set,
  input wire logic i_async_target_rx,
  input wire logic i_first_byte_valid,
  input wire scr_pkg::scr_byte_t i_first_byte,
  input wire logic i_sync_sent,
  input wire logic i_sync_acked,
  input wire logic [15:0] i_bus_sel_ids,
  input wire logic i_bus_sel,
  input wire logic i_bus_resel,
  input wire logic [15:0] i_response_ids,
  // General purpose pins
  input wire logic [4:0] i_gp_dir_out,
  output logic [4:0] o_gp_out,
  output logic [4:0] o_gp_oe_n,
  // Status and control outputs
  output logic o_unexpected_disconnect,
  output logic o_gross_error_interrupt,
  output logic o_count_reload,
  output logic o_wide_xfer,
  output logic o_sync_mode,
  output logic o_offset_stall,
  output logic o_sync_strobe,
  output logic [3:0] o_arb_id,
  output logic [3:0] o_arb_rank,
  output logic [3:0] o_dest_id,
  output logic o_answer_select,
  output logic o_answer_reselect
);
  import scr_pkg::*;
  scr_byte_t ctl_two;
  scr_byte_t ctl_three;
  scr_byte_t own_id;
  scr_byte_t sync_xfer;
  scr_byte_t dest_id;
  scr_byte_t gp_data;
  logic wide_send_residue;
  logic wide_receive_residue;
  logic vendor_group_code_flag;
  logic [5:0] outstanding;
  scr_byte_t rdata;
  scr_div_if div_bus();

  wire wr_two = i_wr && (i_addr == `SCR_OFF_CTL_TWO);
  wire wr_three = i_wr && (i_addr == `SCR_OFF_CTL_THREE);
  wire wr_own = i_wr && (i_addr == `SCR_OFF_OWN_ID);
  wire wr_sync = i_wr && (i_addr == `SCR_OFF_SYNC_XFER);
  wire wr_dest = i_wr && (i_addr == `SCR_OFF_DEST_ID);
  wire wr_gp = i_wr && (i_addr == `SCR_OFF_GP_DATA);
  wire initiator = !i_target_mode_bit;
  wire disconnect_unexpected = ctl_two[`SCR_B_DISC_UNEXP];
  wire count_reload_disable = ctl_two[`SCR_B_RELOAD_DIS];
  wire wide_enable = ctl_three[`SCR_B_WIDE_EN];
  wire [5:0] sync_offset_limit = sync_xfer[5:0];
  // Group codes 0..5 are standard; 6 and 7 are vendor unique.
  wire group_vendor = (i_first_byte[7:5] > `SCR_GRP_STD_MAX);
  wire set_disc = i_script_mode && (i_reselected || i_select_done);
  wire clr_send = wr_two && i_wdata[`SCR_B_WIDE_SEND];
  wire clr_recv = wr_two && i_wdata[`SCR_B_WIDE_RECV];

  // The event set wins over a software write of zero in the same cycle.
  wire next_disc = set_disc ? 1'b1 :
    (wr_two ? i_wdata[`SCR_B_DISC_UNEXP] : disconnect_unexpected);
  wire next_chain = i_chained_block_move ? 1'b1 :
    (i_block_move ? 1'b0 : ctl_two[`SCR_B_CHAINED]);
  wire next_reload_dis = wr_two ? i_wdata[`SCR_B_RELOAD_DIS] : count_reload_disable;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctl_two <= `SCR_RST_VAL;
    end else begin
      ctl_two <= {next_disc, next_chain, 4'h0, next_reload_dis, 1'b0};
    end
  end

  // Residue flags: set wins over the self-clearing write strobe.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wide_send_residue <= 1'b0;
      wide_receive_residue <= 1'b0;
    end else begin
      wide_send_residue <= i_wide_send_set || (wide_send_residue && !clr_send);
      wide_receive_residue <= i_wide_recv_set || (wide_receive_residue && !clr_recv);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      vendor_group_code_flag <= 1'b0;
    end else if (i_async_target_rx && i_first_byte_valid) begin
      vendor_group_code_flag <= group_vendor;
    end
  end

  // Script table loads take precedence over a concurrent processor write.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctl_three <= `SCR_RST_VAL;
      sync_xfer <= `SCR_RST_VAL;
    end else if (i_table_load) begin
      ctl_three <= i_table_ctl_three & `SCR_CTL_THREE_WMASK;
      sync_xfer <= i_table_sync & `SCR_SYNC_XFER_WMASK;
    end else begin
      if (wr_three) begin
        ctl_three <= i_wdata & `SCR_CTL_THREE_WMASK;
      end
      if (wr_sync) begin
        sync_xfer <= i_wdata & `SCR_SYNC_XFER_WMASK;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      own_id <= `SCR_RST_VAL;
      dest_id <= `SCR_RST_VAL;
      gp_data <= `SCR_RST_VAL;
    end else begin
      if (wr_own) begin
        own_id <= i_wdata & `SCR_OWN_ID_WMASK;
      end
      if (i_dest_load) begin
        dest_id <= {4'h0, i_dest_id};
      end else if (wr_dest) begin
        dest_id <= i_wdata & `SCR_DEST_ID_WMASK;
      end
      if (wr_gp) begin
        gp_data <= i_wdata & `SCR_GP_DATA_WMASK;
      end
    end
  end

  // Offset tracking: each i_sync_sent pulse adds one and each i_sync_acked pulse removes one,
  // whether or not i_dt_xfer is set; the count clears outside the data phase or at offset limit zero.
  wire sync_active = i_phase_data && (sync_offset_limit != 6'h00);
  wire [5:0] next_outstanding = !sync_active ? 6'h00 :
    6'(outstanding + {5'h00, i_sync_sent} - {5'h00, i_sync_acked});
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      outstanding <= 6'h00;
    end else begin
      outstanding <= next_outstanding;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_unexpected_disconnect <= 1'b0;
      o_gross_error_interrupt <= 1'b0;
      o_count_reload <= 1'b0;
      o_gp_out <= 5'h00;
      o_gp_oe_n <= 5'h1f;
    end else begin
      o_unexpected_disconnect <= initiator && disconnect_unexpected && i_bus_free;
      o_gross_error_interrupt <= i_dt_xfer && !wide_enable;
      o_count_reload <= i_phase_cmd && i_first_byte_valid && !group_vendor &&
        !count_reload_disable;
      o_gp_out <= gp_data[4:0] & i_gp_dir_out;
      o_gp_oe_n <= ~i_gp_dir_out;
    end
  end

  assign div_bus.sel = ctl_three[6:4];
  scr_clk_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .div(div_bus)
  );
  assign o_sync_strobe = div_bus.strobe;

  scr_prio u_prio (
    .i_id(own_id[3:0]),
    .o_rank(o_arb_rank)
  );
  assign o_arb_id = own_id[3:0];
  assign o_dest_id = dest_id[3:0];
  assign o_wide_xfer = wide_enable && i_phase_data;
  assign o_sync_mode = sync_active;
  assign o_offset_stall = sync_active && (outstanding >= sync_offset_limit);
  wire id_hit = |(i_bus_sel_ids & i_response_ids);
  assign o_answer_reselect = i_bus_resel && id_hit && own_id[`SCR_B_RESEL_EN];
  assign o_answer_select = i_bus_sel && id_hit && own_id[`SCR_B_SEL_EN];

  always_comb begin
    case (i_addr)
      `SCR_OFF_CTL_TWO: rdata = {ctl_two[7:6], 2'h0, wide_send_residue,
        vendor_group_code_flag, ctl_two[1], wide_receive_residue};
      `SCR_OFF_CTL_THREE: rdata = ctl_three;
      `SCR_OFF_OWN_ID: rdata = own_id;
      `SCR_OFF_SYNC_XFER: rdata = sync_xfer;
      `SCR_OFF_DEST_ID: rdata = dest_id;
      `SCR_OFF_GP_DATA: rdata = gp_data;
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata;
    end
  end
endmodule
`default_nettype wire

// *** logic/scr_cfg.svh ***
// Register offsets, field positions, write masks and reset values for the control registers.
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
`define SCR_ADDR_W 4
`define SCR_OFF_CTL_TWO 4'h2
`define SCR_OFF_CTL_THREE 4'h3
`define SCR_OFF_OWN_ID 4'h4
`define SCR_OFF_SYNC_XFER 4'h5
`define SCR_OFF_DEST_ID 4'h6
`define SCR_OFF_GP_DATA 4'h7
`define SCR_B_DISC_UNEXP 7
`define SCR_B_CHAINED 6
`define SCR_B_WIDE_SEND 3
`define SCR_B_VENDOR 2
`define SCR_B_RELOAD_DIS 1
`define SCR_B_WIDE_RECV 0
`define SCR_B_WIDE_EN 3
`define SCR_B_RESEL_EN 6
`define SCR_B_SEL_EN 5
`define SCR_CTL_TWO_WMASK 8'h82
`define SCR_CTL_THREE_WMASK 8'h78
`define SCR_OWN_ID_WMASK 8'h6f
`define SCR_SYNC_XFER_WMASK 8'h3f
`define SCR_DEST_ID_WMASK 8'h0f
`define SCR_GP_DATA_WMASK 8'h1f
`define SCR_RST_VAL 8'h00
`define SCR_GP_DIR_RST 5'h10
`define SCR_GP_W 5
`define SCR_GRP_STD_MAX 3'h5
`endif

// *** logic/scr_pkg.sv ***
// Types shared by the control register block.
package scr_pkg;
  typedef logic [7:0] scr_byte_t;
  typedef logic [3:0] scr_addr_t;
  typedef enum logic [2:0] {
    SCR_DIV_IDLE = 3'b001,
    SCR_DIV_LOW = 3'b010,
    SCR_DIV_HIGH = 3'b100
  } scr_div_state_e;
endpackage

// *** logic/scr_div_if.sv ***
// Divider setting and divided clock strobe between the register block and the divider.
`timescale 1ns/100ps
`default_nettype none
interface scr_div_if;
  logic [2:0] sel;
  logic strobe;
  modport ctrl(output sel, input strobe);
  modport div(input sel, output strobe);
endinterface
`default_nettype wire

// *** logic/scr_clk_div.sv ***
// Synchronous clock divider producing a strobe pattern at the selected factor.
`timescale 1ns/100ps
`default_nettype none
module scr_clk_div (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Setting and strobe
  scr_div_if.div div
);
  import scr_pkg::*;
  // Periods are counted in half core clocks so that 1.5 fits; accumulator step 2.
  logic [4:0] acc;
  logic [4:0] half_period;
  logic [4:0] next_acc;
  logic hit;
  logic strobe;
  always_comb begin
    case (div.sel)
      3'h1: half_period = 5'h02;
      3'h2: half_period = 5'h03;
      3'h3: half_period = 5'h04;
      3'h5: half_period = 5'h08;
      3'h6: half_period = 5'h0c;
      3'h7: half_period = 5'h10;
      default: half_period = 5'h06;
    endcase
  end
  assign hit = (5'(acc + 5'h02) >= half_period);
  assign next_acc = hit ? 5'(acc + 5'h02 - half_period) : 5'(acc + 5'h02);
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      acc <= 5'h00;
      strobe <= 1'b0;
    end else begin
      acc <= next_acc;
      strobe <= hit;
    end
  end
  assign div.strobe = strobe;
endmodule
`default_nettype wire

// *** logic/scr_prio.sv ***
// Arbitration priority rank of a four-bit bus ID.
`timescale 1ns/100ps
`default_nettype none
module scr_prio (
  // ID in
  input wire logic [3:0] i_id,
  // Rank out, 15 is highest
  output logic [3:0] o_rank
);
  import scr_pkg::*;
  // IDs 7..0 outrank 15..8, each group descending.
  assign o_rank = {~i_id[3], i_id[2:0]};
endmodule
`default_nettype wire

// *** dv/scr_ctrl_regs_chk.sv ***
// Port assertions for the control register block.
`timescale 1ns/100ps
`default_nettype none
module scr_ctrl_regs_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_bus_free,
  input wire logic i_phase_data,
  input wire logic i_dt_xfer,
  input wire logic i_first_byte_valid,
  input wire logic i_bus_sel,
  input wire logic i_bus_resel,
  input wire logic [15:0] i_bus_sel_ids,
  input wire logic [15:0] i_response_ids,
  input wire logic [4:0] i_gp_dir_out,
  input wire logic [4:0] o_gp_out,
  input wire logic [4:0] o_gp_oe_n,
  input wire logic o_unexpected_disconnect,
  input wire logic o_gross_error_interrupt,
  input wire logic o_count_reload,
  input wire logic o_wide_xfer,
  input wire logic [3:0] o_arb_id,
  input wire logic [3:0] o_arb_rank,
  input wire logic o_answer_select,
  input wire logic o_answer_reselect
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_disc; $rose(o_unexpected_disconnect) |-> $past(i_bus_free); endproperty
  a_disc: assert property (p_disc) else $error("disconnect flag without bus free");
  property p_gross; $rose(o_gross_error_interrupt) |-> $past(i_dt_xfer); endproperty
  a_gross: assert property (p_gross) else $error("gross error without transfer");
  property p_wide; o_wide_xfer |-> i_phase_data; endproperty
  a_wide: assert property (p_wide) else $error("wide outside data phase");
  property p_rank; o_arb_rank == ((o_arb_id < 4'h8) ? 4'(o_arb_id + 4'h8) : 4'(o_arb_id - 4'h8)); endproperty
  a_rank: assert property (p_rank) else $error("rank wrong");
  property p_sel; o_answer_select |-> i_bus_sel && (i_bus_sel_ids & i_response_ids) != 0; endproperty
  a_sel: assert property (p_sel) else $error("select answered wrongly");
  property p_rsl; o_answer_reselect |-> i_bus_resel && (i_bus_sel_ids & i_response_ids) != 0; endproperty
  a_rsl: assert property (p_rsl) else $error("reselect answered wrongly");
  property p_reload; o_count_reload |-> $past(i_first_byte_valid); endproperty
  a_reload: assert property (p_reload) else $error("reload without first byte");
  property p_gp; !$past(i_rst) |-> o_gp_oe_n == ~$past(i_gp_dir_out) && (o_gp_out & o_gp_oe_n) == 0; endproperty
  a_gp: assert property (p_gp) else $error("pin driven while input");
endmodule
bind scr_ctrl_regs scr_ctrl_regs_chk scr_ctrl_regs_chk_inst (.*);
`default_nettype wire

// *** dv/scr_bus_peer.sv ***
// Far-side bus peer that frees the bus or selects and reselects the core.
`timescale 1ns/100ps
`default_nettype none
module scr_bus_peer (
  // Clock and request: 0 hold, 1 bus free, 2 select, 3 reselect
  input wire logic i_ref_clk,
  input wire logic [1:0] i_req,
  input wire logic [3:0] i_id,
  // Bus view
  output logic o_bus_free,
  output logic o_bus_sel,
  output logic o_bus_resel,
  output logic [15:0] o_sel_ids
);
  // Released ID lines invert every cycle, so a stale ID comes back every second cycle.
  always_ff @(posedge i_ref_clk) begin
    o_bus_free <= i_req == 2'h1;
    o_bus_sel <= i_req == 2'h2;
    o_bus_resel <= i_req == 2'h3;
    o_sel_ids <= i_req[1] ? 16'h0001 << i_id : ~o_sel_ids;
  end
endmodule
`default_nettype wire

// *** dv/test_scsi_core_control_regs.sv ***
// Self-checking bench for the control register block.
`timescale 1ns/100ps
`default_nettype none
module test_scsi_core_control_regs;
  import scr_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_target_mode_bit = 0, i_phase_data = 0;
  logic i_phase_cmd = 0, i_dt_xfer = 0, i_script_mode = 0, i_async_target_rx = 0, rl;
  logic i_reselected, i_select_done, i_chained_block_move, i_block_move, i_table_load;
  logic i_dest_load, i_wide_send_set, i_wide_recv_set, i_first_byte_valid, i_sync_sent;
  logic i_sync_acked, i_bus_free, i_bus_sel, i_bus_resel, o_unexpected_disconnect;
  logic o_gross_error_interrupt, o_count_reload, o_wide_xfer, o_sync_mode, o_offset_stall;
  logic o_sync_strobe, o_answer_select, o_answer_reselect;
  logic [15:0] i_bus_sel_ids, i_response_ids = 16'h0008;
  logic [10:0] ev = 11'h000;
  logic [3:0] i_dest_id = 4'h9, o_arb_id, o_arb_rank, o_dest_id, pid = 4'h3;
  logic [4:0] i_gp_dir_out = 5'h00, o_gp_out, o_gp_oe_n;
  logic [1:0] req = 2'h0;
  scr_addr_t i_addr = 4'h0;
  scr_byte_t i_wdata = 8'h00, i_table_ctl_three = 8'h38, i_table_sync = 8'h05;
  scr_byte_t i_first_byte = 8'h00, o_rdata;
  scr_byte_t msk[9] = '{8'h00, 8'h00, 8'h82, 8'h78, 8'h6f, 8'h3f, 8'h0f, 8'h1f, 8'h00};
  int checks = 0, miscompares = 0, n;
  int f2[8] = '{6, 2, 3, 4, 6, 8, 12, 16};
  assign {i_sync_acked, i_sync_sent, i_first_byte_valid, i_wide_recv_set, i_wide_send_set} = ev[10:6];
  assign {i_dest_load, i_table_load, i_block_move, i_chained_block_move} = ev[5:2];
  assign {i_select_done, i_reselected} = ev[1:0];
  scr_ctrl_regs scr_ctrl_regs_inst (.*);
  scr_bus_peer scr_bus_peer_inst (.i_ref_clk, .i_req(req), .i_id(pid), .o_bus_free(i_bus_free),
    .o_bus_sel(i_bus_sel), .o_bus_resel(i_bus_resel), .o_sel_ids(i_bus_sel_ids));
  always #10 i_ref_clk = ~i_ref_clk;
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic c1(input string s, input logic e, input logic g);
    chk(s, {7'h0, e}, {7'h0, g});
  endtask
  task automatic wr(input scr_addr_t a, input scr_byte_t d);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input scr_addr_t a, input scr_byte_t e);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    @(negedge i_ref_clk);
    chk("rdata", e, o_rdata);
    @(posedge i_ref_clk);
  endtask
  // Events are one-cycle pulses; the reload output is caught in the following cycle.
  task automatic pulse(input int k);
    ev[k] <= 1'h1;
    @(posedge i_ref_clk);
    ev <= 11'h000;
    @(negedge i_ref_clk);
    rl = o_count_reload;
    @(posedge i_ref_clk);
  endtask
  task automatic wait_look(input int c);
    repeat (c) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge i_ref_clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    @(posedge i_ref_clk);
    for (int a = 2; a < 9; a++) rd(4'(a), 8'h00);
    for (int a = 2; a < 9; a++) begin
      wr(4'(a), 8'hff);
      rd(4'(a), msk[a]);
    end
    chk("rank", 8'h07, {4'h0, o_arb_rank});
    $display("test registers done");
    wr(4'h2, 8'h00);
    i_script_mode <= 1'h1;
    pulse(0);
    rd(4'h2, 8'h80);
    req <= 2'h1;
    wait_look(2);
    c1("disconnect", 1'h1, o_unexpected_disconnect);
    @(posedge i_ref_clk);
    wr(4'h2, 8'h00);
    @(negedge i_ref_clk);
    c1("disconnect", 1'h0, o_unexpected_disconnect);
    @(posedge i_ref_clk);
    req <= 2'h0;
    pulse(2);
    rd(4'h2, 8'h40);
    pulse(3);
    pulse(6);
    pulse(7);
    rd(4'h2, 8'h09);
    wr(4'h2, 8'h89);
    rd(4'h2, 8'h80);
    $display("test flags done");
    i_async_target_rx <= 1'h1;
    i_first_byte <= 8'hc0;
    pulse(8);
    rd(4'h2, 8'h84);
    i_async_target_rx <= 1'h0;
    i_phase_cmd <= 1'h1;
    i_first_byte <= 8'h28;
    pulse(8);
    c1("reload", 1'h1, rl);
    wr(4'h2, 8'h02);
    pulse(8);
    c1("reload", 1'h0, rl);
    i_phase_cmd <= 1'h0;
    $display("test group code done");
    for (int e = 0; e < 8; e++) begin
      wr(4'h3, {1'h0, 3'(e), 4'h0});
      repeat (4) @(posedge i_ref_clk);
      n = 0;
      repeat (48) @(negedge i_ref_clk) n += int'(o_sync_strobe === 1'h1);
      @(posedge i_ref_clk);
      chk("strobes", 8'(96 / f2[e]), 8'(n));
    end
    i_phase_data <= 1'h1;
    i_dt_xfer <= 1'h1;
    wait_look(2);
    c1("wide", 1'h0, o_wide_xfer);
    c1("gross", 1'h1, o_gross_error_interrupt);
    @(posedge i_ref_clk);
    wr(4'h3, 8'h08);
    @(negedge i_ref_clk);
    c1("wide", 1'h1, o_wide_xfer);
    c1("gross", 1'h0, o_gross_error_interrupt);
    @(posedge i_ref_clk);
    i_dt_xfer <= 1'h0;
    pulse(4);
    rd(4'h3, 8'h38);
    rd(4'h5, 8'h05);
    c1("sync", 1'h1, o_sync_mode);
    pulse(5);
    rd(4'h6, 8'h09);
    chk("dest", 8'h09, {4'h0, o_dest_id});
    // The table loaded an offset limit of five, so the fifth unanswered transfer stalls.
    for (int k = 0; k < 4; k++) pulse(9);
    wait_look(0);
    c1("stall", 1'h0, o_offset_stall);
    @(posedge i_ref_clk);
    pulse(9);
    wait_look(0);
    c1("stall", 1'h1, o_offset_stall);
    @(posedge i_ref_clk);
    pulse(10);
    wait_look(0);
    c1("stall", 1'h0, o_offset_stall);
    @(posedge i_ref_clk);
    wr(4'h5, 8'h00);
    wait_look(0);
    c1("sync", 1'h0, o_sync_mode);
    c1("stall", 1'h0, o_offset_stall);
    @(posedge i_ref_clk);
    $display("test loads done");
    req <= 2'h2;
    wait_look(2);
    c1("select", 1'h1, o_answer_select);
    @(posedge i_ref_clk);
    req <= 2'h3;
    pid <= 4'h2;
    wait_look(2);
    c1("reselect", 1'h0, o_answer_reselect);
    @(posedge i_ref_clk);
    pid <= 4'h3;
    wait_look(2);
    c1("reselect", 1'h1, o_answer_reselect);
    @(posedge i_ref_clk);
    req <= 2'h0;
    wr(4'h7, 8'h15);
    i_gp_dir_out <= 5'h03;
    wait_look(2);
    chk("pins", 8'h01, {3'h0, o_gp_out});
    chk("enables", 8'h1c, {3'h0, o_gp_oe_n});
    $display("test bus and pins done");
    end_of_test();
  end
endmodule
`default_nettype wire
